// ===== pkg/cpcr_pkg.sv
// Operation
// - enable bit drives clock out, resets one
// - divisor zero passes crystal clock through
// - nonzero divisor gives crystal over 2N
// - divisor resets fifteen, output enabled
// - reserved bits zero, written as zero
// - manchester enable bit, resets cleared
// - fixed format: exact payload length
// - variable format: rx maximum, tx ignored
// - node address register for rx filtering
// - filter: off, node, +00, +00/FF
// - length format bit selects variable, resets zero
package cpcr_pkg;

  // ----------------------------------------
  // register map (index, byte address = 4 x index)
  // ----------------------------------------
  localparam int ADDR_W = 10;
  localparam logic [7:0] CLKOUT_IDX = 8'h1B;
  localparam logic [7:0] PAYLOAD_IDX = 8'h1C;
  localparam logic [7:0] NODE_IDX = 8'h1D;
  localparam logic [7:0] PKTCFG_IDX = 8'h1E;
  localparam logic [7:0] STATUS_IDX = 8'h20;

  // ----------------------------------------
  // fields
  // ----------------------------------------
  localparam int CLKEN_BIT = 7;
  localparam int DIV_LSB = 2;
  localparam int DIV_W = 5;
  localparam int MANCH_BIT = 7;
  localparam int LEN_W = 7;
  localparam int LENF_BIT = 7;
  localparam int AFM_LSB = 1;
  localparam int RUN_BIT = 24;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] CLKOUT_RST = 8'hBC;
  localparam logic [7:0] CLKOUT_RSV_MASK = 8'h03;
  localparam logic [7:0] PAYLOAD_RST = 8'h00;
  localparam logic [7:0] NODE_RST = 8'h00;
  localparam logic [7:0] PKTCFG_RST = 8'h00;
  localparam logic [4:0] DIV_RST = 5'h0F;
  localparam logic [7:0] BCAST_ZERO = 8'h00;
  localparam logic [7:0] BCAST_ONES = 8'hFF;

  typedef enum logic [1:0] {
    AFM_OFF,
    AFM_NODE,
    AFM_NODE_ZERO,
    AFM_NODE_BOTH
  } cpcr_afm_t;

endpackage

// ===== testbench/clkout_payload_config_regs_tb_top.sv
`timescale 1ns/100ps
module clkout_payload_config_regs_tb_top;
  import cpcr_pkg::*;
  logic clk, rst, psel, penable, pwrite, a_vld, l_vld, err, ok, bad;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, clkout, manch, var_len, tx_used, acc, rej, l_ok, l_err;
  logic [LEN_W-1:0] tx_len, rx_lim;
  logic [7:0] a_byte, l_byte, hi_len, lo_len, node, pay, v;
  logic xp;
  int err_total, num_checks, n, old_n, cnt, accs, rejs, lerrs;

  cpcr_regs i_dut (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .CLKOUT_O(clkout), .MANCH_EN_O(manch),
    .VAR_LEN_O(var_len), .TX_LEN_O(tx_len), .TX_LEN_USED_O(tx_used),
    .RX_LEN_LIMIT_O(rx_lim), .RX_ADDR_VALID_I(a_vld), .RX_ADDR_I(a_byte),
    .RX_ADDR_ACCEPT_O(acc), .RX_ADDR_REJECT_O(rej), .RX_LEN_VALID_I(l_vld),
    .RX_LEN_I(l_byte), .RX_LEN_OK_O(l_ok), .RX_LEN_ERR_O(l_err));

  cpcr_host_model i_host (.clk_i(clk), .clkout_i(clkout), .hi_len_o(hi_len),
    .lo_len_o(lo_len));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // one apb transfer; waits on pready, bounded
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      check(32'h0, 32'h1, "apb hang");
      test_done();
    end
  endtask

  // one-cycle receive strobe, verdict taken one cycle later
  task automatic strobe(input logic is_addr, input logic [7:0] b);
    @(posedge clk);
    a_vld <= is_addr;
    l_vld <= !is_addr;
    a_byte <= b;
    l_byte <= b;
    @(posedge clk);
    a_vld <= 1'b0;
    l_vld <= 1'b0;
    #1;
    ok = is_addr ? acc : l_ok;
    bad = is_addr ? rej : l_err;
  endtask

  function automatic logic exp_acc(input logic [1:0] m, input logic [7:0] nd,
                                   input logic [7:0] a);
    return m == 2'h0 || a == nd || (m[1] && a == 8'h00) || (m == 2'h3 && a == 8'hFF);
  endfunction

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {rst, psel, penable, pwrite, a_vld, l_vld} = 6'h20;
    {paddr, pwdata, a_byte, l_byte} = '0;
    void'($urandom(9938));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    apb(0, CLKOUT_IDX, 0);
    check(rd, {24'h0, CLKOUT_RST}, "clkout reset");
    apb(0, PAYLOAD_IDX, 0);
    check(rd, 32'h0, "payload reset");
    apb(0, NODE_IDX, 0);
    check(rd, 32'h0, "node reset");
    apb(0, PKTCFG_IDX, 0);
    check(rd, 32'h0, "format reset");
    apb(0, 8'h3F, 0);
    check({rd[30:0], err}, 32'h1, "unmapped read");
    repeat (80) @(posedge clk);
    check(hi_len, 8'h0F, "default high");
    check(lo_len, 8'h0F, "default low");
    // reserved bits written as ones on purpose: must still store zero
    old_n = 15;
    for (int i = 0; i < 8; i++) begin
      n = (i == 0) ? 1 : (i == 1) ? 31 : $urandom_range(31, 1);
      apb(1, CLKOUT_IDX, {24'h0, 1'b1, n[4:0], 2'b11});
      repeat (2 * old_n + 6 * n + 10) @(posedge clk);
      check(hi_len, n[7:0], "div high");
      check(lo_len, n[7:0], "div low");
      old_n = n;
    end
    apb(0, CLKOUT_IDX, 0);
    check(rd, {24'h0, 1'b1, n[4:0], 2'b00}, "reserved bits");
    apb(1, CLKOUT_IDX, 32'h80);
    repeat (2 * old_n + 10) @(posedge clk);
    repeat (4) begin
      @(negedge clk);
      #1;
      check(clkout, 1'b0, "bypass low");
      @(posedge clk);
      #1;
      check(clkout, 1'b1, "bypass high");
    end
    apb(1, CLKOUT_IDX, 32'h3C);
    repeat (40) @(posedge clk);
    cnt = 0;
    repeat (100) begin
      @(negedge clk);
      if (clkout !== 1'b0) cnt++;
    end
    check(cnt, 0, "disabled output");
    apb(1, CLKOUT_IDX, 32'h88);
    repeat (30) @(posedge clk);
    check(hi_len, 8'h02, "re-enabled");
    for (int i = 0; i < 6; i++) begin
      pay = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
      apb(1, PAYLOAD_IDX, {24'h0, pay});
      apb(1, PKTCFG_IDX, {24'h0, i[0], 7'h0});
      repeat (3) @(posedge clk);
      check(manch, pay[7], "manchester");
      check(tx_len, pay[6:0], "tx length");
      check(rx_lim, pay[6:0], "rx limit");
      check(var_len, i[0], "format");
      check(tx_used, !i[0], "tx length use");
      apb(0, PAYLOAD_IDX, 0);
      check(rd, {24'h0, pay}, "payload read");
      for (int j = 0; j < 3; j++) begin
        v = {1'b0, pay[6:0]} + ((j == 1) ? 8'h01 : (j == 2) ? 8'hFF : 8'h00);
        xp = i[0] ? (v <= {1'b0, pay[6:0]}) : (v == {1'b0, pay[6:0]});
        strobe(0, v);
        check(ok, xp, "length ok");
        check(bad, !xp, "length err");
        if (!xp) lerrs++;
      end
    end
    node = 8'($urandom);
    apb(1, NODE_IDX, {24'h0, node});
    apb(0, NODE_IDX, 0);
    check(rd, {24'h0, node}, "node read");
    for (int m = 0; m < 4; m++) begin
      apb(1, PKTCFG_IDX, {29'h0, m[1:0], 1'b0});
      repeat (3) @(posedge clk);
      for (int j = 0; j < 4; j++) begin
        v = (j == 0) ? node : (j == 1) ? 8'h00 : (j == 2) ? 8'hFF : 8'($urandom);
        strobe(1, v);
        check(ok, exp_acc(m[1:0], node, v), "accept");
        check(bad, !exp_acc(m[1:0], node, v), "reject");
        if (exp_acc(m[1:0], node, v)) accs++;
        else rejs++;
      end
    end
    // status: verdict tallies since reset, clock out still enabled
    apb(0, STATUS_IDX, 0);
    check(rd, {7'h0, 1'b1, 8'(lerrs), 8'(rejs), 8'(accs)}, "status counts");
    apb(1, STATUS_IDX, 0);
    apb(0, STATUS_IDX, 0);
    check(rd, {7'h0, 1'b1, 24'h0}, "status clear");
    test_done();
  end
endmodule // clkout_payload_config_regs_tb_top

// ===== testbench/cpcr_host_model.sv
`timescale 1ns/100ps
module cpcr_host_model (
  // crystal clock and divided clock from the device
  input wire logic clk_i,
  input wire logic clkout_i,
  // last complete phase lengths in crystal cycles
  output logic [7:0] hi_len_o,
  output logic [7:0] lo_len_o
);
  logic last_lvl;
  logic [7:0] run_len;

  // ----------------------------------------
  // phase measurement
  // ----------------------------------------
  // sampled on the falling edge: a bypassed clock then reads as steady low
  initial begin
    hi_len_o = 8'h00;
    lo_len_o = 8'h00;
    last_lvl = 1'b0;
    run_len = 8'h00;
  end

  always @(negedge clk_i) begin
    if (clkout_i !== last_lvl) begin
      if (last_lvl === 1'b1) hi_len_o <= run_len;
      else lo_len_o <= run_len;
      run_len <= 8'h01;
    end else if (run_len != 8'hFF) begin
      run_len <= run_len + 8'h01;
    end
    last_lvl <= clkout_i;
  end
endmodule // cpcr_host_model

// ===== verilog/cpcr_addr_filt.sv
`timescale 1ns/100ps
module cpcr_addr_filt
  import cpcr_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // settings
  input wire logic [1:0] mode_i,
  input wire logic [7:0] node_i,
  // address byte in
  input wire logic valid_i,
  input wire logic [7:0] addr_i,
  // verdict
  output logic accept_o,
  output logic reject_o
);
  function automatic logic addr_match(input logic [1:0] m, input logic [7:0] n,
                                      input logic [7:0] a);
    case (cpcr_afm_t'(m))
      AFM_OFF: addr_match = 1'b1;
      AFM_NODE: addr_match = (a == n);
      AFM_NODE_ZERO: addr_match = (a == n) || (a == BCAST_ZERO);
      AFM_NODE_BOTH: addr_match = (a == n) || (a == BCAST_ZERO) || (a == BCAST_ONES);
      default: addr_match = 1'b0;
    endcase
  endfunction

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      accept_o <= 1'b0;
      reject_o <= 1'b0;
    end else begin
      accept_o <= valid_i && addr_match(mode_i, node_i, addr_i);
      reject_o <= valid_i && !addr_match(mode_i, node_i, addr_i);
    end
  end

  chk_verdict_once: assert property (@(posedge clk_i) disable iff (rst_i)
    valid_i |=> accept_o != reject_o) else $error("no single verdict");
  chk_node_pass: assert property (@(posedge clk_i) disable iff (rst_i)
    valid_i && addr_i == node_i |=> accept_o) else $error("own node rejected");
  chk_ff_reject: assert property (@(posedge clk_i) disable iff (rst_i)
    valid_i && mode_i != 2'h3 && mode_i != 2'h0 && addr_i == 8'hFF && node_i != 8'hFF
    |=> reject_o) else $error("FF wrongly accepted");
endmodule // cpcr_addr_filt

// ===== verilog/cpcr_clkdiv.sv
`timescale 1ns/100ps
module cpcr_clkdiv
  import cpcr_pkg::*;
#(
  parameter int DW = DIV_W
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // settings
  input wire logic en_i,
  input wire logic [DW-1:0] div_i,
  // clock out
  output logic clk_o,
  output logic running_o
);
  initial if (DW < 1 || DW > 8) $error("cpcr_clkdiv: bad DW");

  logic [DW-1:0] cnt_reg;
  logic [DW-1:0] act_div_reg;
  logic act_en_reg;
  logic tgl_reg;
  logic dividing;
  logic half_end;
  logic reload;

  always_comb begin
    dividing = act_en_reg && (act_div_reg != '0);
    half_end = dividing && (cnt_reg == act_div_reg - 1'b1);
    reload = !dividing || (half_end && tgl_reg);
  end

  // while dividing, new settings only at the end of a low-high pair; when off or bypassed, every cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
      tgl_reg <= 1'b0;
      act_en_reg <= CLKOUT_RST[CLKEN_BIT];
      act_div_reg <= DW'(DIV_RST);
    end else if (reload) begin
      act_en_reg <= en_i;
      act_div_reg <= div_i;
      cnt_reg <= '0;
      tgl_reg <= 1'b0;
    end else if (half_end) begin
      cnt_reg <= '0;
      tgl_reg <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  logic byp_sel_reg;

  // mux select moves only while the crystal is low, so no runt pulse
  always_ff @(negedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      byp_sel_reg <= 1'b0;
    end else begin
      byp_sel_reg <= act_en_reg && (act_div_reg == '0);
    end
  end

  // bypass passes the crystal itself
  assign clk_o = byp_sel_reg ? clk_i : tgl_reg;
  assign running_o = act_en_reg;

  chk_half_toggle: assert property (@(posedge clk_i) disable iff (rst_i)
    half_end |=> tgl_reg != $past(tgl_reg)) else $error("half period missed");
  chk_off_low: assert property (@(posedge clk_i) disable iff (rst_i)
    !act_en_reg |-> !tgl_reg) else $error("clock out active while off");
  chk_reload_edge: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(act_div_reg) |-> $past(reload) && !tgl_reg) else $error("divisor glitch");
endmodule // cpcr_clkdiv

// ===== verilog/cpcr_regs.sv
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/100ps
module cpcr_regs
  import cpcr_pkg::*;
#(
  parameter int CNT_W = 8
) (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,

  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [ADDR_W-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,

  // clock output pin
  output logic CLKOUT_O,

  // packet settings to the modem
  output logic MANCH_EN_O,
  output logic VAR_LEN_O,
  output logic [LEN_W-1:0] TX_LEN_O,
  output logic TX_LEN_USED_O,
  output logic [LEN_W-1:0] RX_LEN_LIMIT_O,

  // receive address byte
  input wire logic RX_ADDR_VALID_I,
  input wire logic [7:0] RX_ADDR_I,
  output logic RX_ADDR_ACCEPT_O,
  output logic RX_ADDR_REJECT_O,

  // receive length byte
  input wire logic RX_LEN_VALID_I,
  input wire logic [7:0] RX_LEN_I,
  output logic RX_LEN_OK_O,
  output logic RX_LEN_ERR_O
);

  initial if (CNT_W < 1 || CNT_W > 8) $error("cpcr_regs: bad CNT_W");

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    addr_is = (a == {idx, 2'b00});
  endfunction

  logic sel_clk;
  logic sel_pay;
  logic sel_node;
  logic sel_pkt;
  logic sel_stat;
  logic addr_hit;
  logic wr_acc;
  logic rd_setup;

  always_comb begin
    sel_clk = addr_is(PADDR_I, CLKOUT_IDX);
    sel_pay = addr_is(PADDR_I, PAYLOAD_IDX);
    sel_node = addr_is(PADDR_I, NODE_IDX);
    sel_pkt = addr_is(PADDR_I, PKTCFG_IDX);
    sel_stat = addr_is(PADDR_I, STATUS_IDX);
    addr_hit = sel_clk || sel_pay || sel_node || sel_pkt || sel_stat;
    wr_acc = PSEL_I && PENABLE_I && PWRITE_I && addr_hit;
    rd_setup = PSEL_I && !PENABLE_I && !PWRITE_I;
  end

  // zero wait states: every access completes in its first access cycle
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && !addr_hit;

  // ----------------------------------------
  // clock output control
  // ----------------------------------------
  logic [7:0] clkctl_reg;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      clkctl_reg <= CLKOUT_RST;
    end else if (wr_acc && sel_clk) begin
      // reserved bits never store a one
      clkctl_reg <= PWDATA_I[7:0] & ~CLKOUT_RSV_MASK;
    end
  end

  logic clk_en;
  logic [DIV_W-1:0] clk_div;
  logic clk_running;

  assign clk_en = clkctl_reg[CLKEN_BIT];
  assign clk_div = clkctl_reg[DIV_LSB +: DIV_W];

  cpcr_clkdiv #(
    .DW(DIV_W)
  ) u_clkdiv (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .en_i(clk_en),
    .div_i(clk_div),
    .clk_o(CLKOUT_O),
    .running_o(clk_running)
  );

  // ----------------------------------------
  // payload config
  // ----------------------------------------
  logic [7:0] payload_reg;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      payload_reg <= PAYLOAD_RST;
    end else if (wr_acc && sel_pay) begin
      payload_reg <= PWDATA_I[7:0];
    end
  end

  logic manch_en;
  logic [LEN_W-1:0] pay_len;

  assign manch_en = payload_reg[MANCH_BIT];
  assign pay_len = payload_reg[LEN_W-1:0];

  // ----------------------------------------
  // node address
  // ----------------------------------------
  logic [7:0] node_reg;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      node_reg <= NODE_RST;
    end else if (wr_acc && sel_node) begin
      node_reg <= PWDATA_I[7:0];
    end
  end

  // ----------------------------------------
  // packet config (format and filter mode)
  // ----------------------------------------
  logic [7:0] pktcfg_reg;
  logic [7:0] pktcfg_mask;

  // only the format and filter bits are held here; the rest read zero
  assign pktcfg_mask = 8'h86;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pktcfg_reg <= PKTCFG_RST;
    end else if (wr_acc && sel_pkt) begin
      pktcfg_reg <= PWDATA_I[7:0] & pktcfg_mask;
    end
  end

  logic var_len;
  logic [1:0] filt_mode;

  assign var_len = pktcfg_reg[LENF_BIT];
  assign filt_mode = pktcfg_reg[AFM_LSB +: 2];

  // ----------------------------------------
  // settings to the modem
  // ----------------------------------------
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      MANCH_EN_O <= 1'b0;
      VAR_LEN_O <= 1'b0;
      TX_LEN_O <= '0;
      TX_LEN_USED_O <= 1'b1;
      RX_LEN_LIMIT_O <= '0;
    end else begin
      MANCH_EN_O <= manch_en;
      VAR_LEN_O <= var_len;
      TX_LEN_O <= pay_len;
      TX_LEN_USED_O <= !var_len;
      RX_LEN_LIMIT_O <= pay_len;
    end
  end

  // ----------------------------------------
  // address filter
  // ----------------------------------------
  cpcr_addr_filt u_filt (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .mode_i(filt_mode),
    .node_i(node_reg),
    .valid_i(RX_ADDR_VALID_I),
    .addr_i(RX_ADDR_I),
    .accept_o(RX_ADDR_ACCEPT_O),
    .reject_o(RX_ADDR_REJECT_O)
  );

  // ----------------------------------------
  // receive length check
  // ----------------------------------------
  logic len_fits;
  logic [7:0] len_ext;

  always_comb begin
    len_ext = {1'b0, pay_len};
    if (var_len) begin
      len_fits = (RX_LEN_I <= len_ext);
    end else begin
      len_fits = (RX_LEN_I == len_ext);
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      RX_LEN_OK_O <= 1'b0;
      RX_LEN_ERR_O <= 1'b0;
    end else begin
      RX_LEN_OK_O <= RX_LEN_VALID_I && len_fits;
      RX_LEN_ERR_O <= RX_LEN_VALID_I && !len_fits;
    end
  end

  // ----------------------------------------
  // status counters
  // ----------------------------------------
  logic [CNT_W-1:0] acc_cnt_reg;
  logic [CNT_W-1:0] rej_cnt_reg;
  logic [CNT_W-1:0] lerr_cnt_reg;
  logic stat_clr;

  // counters saturate so a long run never wraps to a small value
  assign stat_clr = wr_acc && sel_stat;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      acc_cnt_reg <= '0;
    end else if (stat_clr) begin
      acc_cnt_reg <= RX_ADDR_ACCEPT_O ? CNT_W'(1) : '0;
    end else if (RX_ADDR_ACCEPT_O && acc_cnt_reg != '1) begin
      acc_cnt_reg <= acc_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rej_cnt_reg <= '0;
    end else if (stat_clr) begin
      rej_cnt_reg <= RX_ADDR_REJECT_O ? CNT_W'(1) : '0;
    end else if (RX_ADDR_REJECT_O && rej_cnt_reg != '1) begin
      rej_cnt_reg <= rej_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      lerr_cnt_reg <= '0;
    end else if (stat_clr) begin
      lerr_cnt_reg <= RX_LEN_ERR_O ? CNT_W'(1) : '0;
    end else if (RX_LEN_ERR_O && lerr_cnt_reg != '1) begin
      lerr_cnt_reg <= lerr_cnt_reg + 1'b1;
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  logic [31:0] rd_next;

  always_comb begin
    rd_next = '0;
    if (sel_clk) begin
      rd_next[7:0] = clkctl_reg;
    end else if (sel_pay) begin
      rd_next[7:0] = payload_reg;
    end else if (sel_node) begin
      rd_next[7:0] = node_reg;
    end else if (sel_pkt) begin
      rd_next[7:0] = pktcfg_reg;
    end else if (sel_stat) begin
      rd_next[CNT_W-1:0] = acc_cnt_reg;
      rd_next[8 +: CNT_W] = rej_cnt_reg;
      rd_next[16 +: CNT_W] = lerr_cnt_reg;
      rd_next[RUN_BIT] = clk_running;
    end
  end

  // captured in setup so the access phase sees settled data
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      PRDATA_O <= '0;
    end else if (rd_setup) begin
      PRDATA_O <= rd_next;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_rsv_zero: assert property (@(posedge CLK_I) disable iff (RST_I)
    (clkctl_reg & CLKOUT_RSV_MASK) == 8'h00) else $error("reserved bits set");

  chk_clk_write: assert property (@(posedge CLK_I) disable iff (RST_I)
    wr_acc && sel_clk |=> clkctl_reg[7] == $past(PWDATA_I[7]))
    else $error("enable not stored");

  chk_off_quiet: assert property (@(posedge CLK_I) disable iff (RST_I)
    !clk_running |-> !CLKOUT_O) else $error("clock out not held low");

  chk_manch_follow: assert property (@(posedge CLK_I) disable iff (RST_I)
    wr_acc && sel_pay ##1 1'b1 |=> MANCH_EN_O == payload_reg[7])
    else $error("manchester enable lags");

  chk_tx_len_use: assert property (@(posedge CLK_I) disable iff (RST_I)
    $rose(var_len) |=> !TX_LEN_USED_O) else $error("tx length used in variable");

  chk_len_var: assert property (@(posedge CLK_I) disable iff (RST_I)
    RX_LEN_VALID_I && var_len && RX_LEN_I > {1'b0, pay_len} |=> RX_LEN_ERR_O)
    else $error("oversize length accepted");

  chk_len_fixed: assert property (@(posedge CLK_I) disable iff (RST_I)
    RX_LEN_VALID_I && !var_len && RX_LEN_I == {1'b0, pay_len} |=> RX_LEN_OK_O)
    else $error("exact length refused");

  chk_filt_off: assert property (@(posedge CLK_I) disable iff (RST_I)
    RX_ADDR_VALID_I && filt_mode == 2'h0 |=> RX_ADDR_ACCEPT_O)
    else $error("filter off rejected");

  chk_node_write: assert property (@(posedge CLK_I) disable iff (RST_I)
    wr_acc && sel_node |=> node_reg == $past(PWDATA_I[7:0]))
    else $error("node address not stored");

  chk_unmapped_err: assert property (@(posedge CLK_I) disable iff (RST_I)
    PSEL_I && PENABLE_I && !addr_hit |-> PSLVERR_O && PREADY_O)
    else $error("unmapped access not flagged");

  chk_stat_clear: assert property (@(posedge CLK_I) disable iff (RST_I)
    stat_clr |=> acc_cnt_reg == ($past(RX_ADDR_ACCEPT_O) ? CNT_W'(1) : '0))
    else $error("counter clear wrong");

endmodule // cpcr_regs
